// file: bench/pirq_periph_model.sv
// Peripheral-side model: event strobes and serial buffer levels.
// Assumes bench requests change just after rising edges of clk_in.
`timescale 1ns/10ps
`default_nettype none

module pirq_periph_model #(parameter int DEPTH = 2) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Requests from the bench
  input wire logic fire_in,
  input wire pirq_pkg::pirq_events_t ev_in,
  input wire logic rx_push_in,
  input wire logic rx_pop_in,
  input wire logic tx_push_in,
  input wire logic tx_drain_in,
  // Toward the flag block
  output pirq_pkg::pirq_events_t events_out,
  output pirq_pkg::pirq_serial_t serial_out
);
  pirq_pkg::pirq_events_t ev_reg;
  logic [1:0] rx_reg;
  logic [1:0] tx_reg;

  // ==========================================================
  // Strobes last one cycle; buffer counts saturate
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ev_reg <= '0;
      rx_reg <= 2'h0;
      tx_reg <= 2'h0;
    end else begin
      ev_reg <= fire_in ? ev_in : '0;
      rx_reg <= rx_reg + 2'(rx_push_in && rx_reg < DEPTH)
                - 2'(rx_pop_in && rx_reg != 0);
      tx_reg <= tx_reg + 2'(tx_push_in && tx_reg < DEPTH)
                - 2'(tx_drain_in && tx_reg != 0);
    end
  end

  // Qualifier levels pass through live
  always_comb begin
    events_out = ev_reg;
    events_out.zc_rise_en = ev_in.zc_rise_en;
    events_out.zc_fall_en = ev_in.zc_fall_en;
    events_out.t8_ratio_one = ev_in.t8_ratio_one;
  end

  // Buffer levels seen by the flag block
  assign serial_out = {rx_reg != 2'h0, tx_reg < DEPTH, tx_reg == 2'h0};
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the flag block, random with corner cases.
// Assumes the peripheral model drives events and buffer levels.
`timescale 1ns/10ps
`default_nettype none
`include "pirq_consts.svh"
`define TB_CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end end

module tb_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic fire = 1'b0;
  logic rx_push = 1'b0;
  logic rx_pop = 1'b0;
  logic tx_push = 1'b0;
  logic tx_drain = 1'b0;
  logic irq;
  pirq_pkg::pirq_events_t ev = '0;
  pirq_pkg::pirq_events_t events;
  pirq_pkg::pirq_serial_t serial;
  pirq_pkg::pirq_enables_t ens = '0;
  pirq_pkg::pirq_flags_t flags;
  pirq_pkg::pirq_flags_t exp_f = '0;
  int num_errors = 0;
  int compares = 0;
  int rx_n = 0;
  int tx_n = 0;
  logic [4:0] offs [3] = '{`PIRQ_OFS_ANALOG, `PIRQ_OFS_SERIAL,
                           `PIRQ_OFS_TIMER};

  // ==========================================================
  // Clock, design and peripheral model
  always #20 clk_in = ~clk_in;

  pirq_flags u_pirq_flags (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .events_in(events), .serial_in(serial), .enables_in(ens),
    .flags_out(flags), .irq_request_out(irq));

  pirq_periph_model u_pirq_periph_model (.clk_in(clk_in),
    .rstn_in(rstn_in), .fire_in(fire), .ev_in(ev),
    .rx_push_in(rx_push), .rx_pop_in(rx_pop), .tx_push_in(tx_push),
    .tx_drain_in(tx_drain), .events_out(events), .serial_out(serial));

  // ==========================================================
  // Expectation helpers
  function automatic pirq_pkg::pirq_flags_t ev_flags(
      input pirq_pkg::pirq_events_t e);
    pirq_pkg::pirq_flags_t f;
    logic [2:0] t8;
    f = '0;
    t8 = e.t8_post_ovf | (e.t8_match & e.t8_ratio_one);
    f.analog[6] = (e.zc_rise & e.zc_rise_en)
                  | (e.zc_fall & e.zc_fall_en);
    f.analog[1:0] = {e.cmp_b, e.cmp_a};
    f.serial[3:0] = {e.spb_col, e.spb_done, e.spa_col, e.spa_done};
    f.timer[5:0] = {t8[2], e.t16_ovf[2], t8[1], e.t16_ovf[1], t8[0],
                    e.t16_ovf[0]};
    return f;
  endfunction

  function automatic logic [7:0] ser_exp();
    return {2'b00, rx_n != 0, tx_n < 2, exp_f.serial[3:0]};
  endfunction

  // ==========================================================
  // Avalon-MM cycle: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    be <= b;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    // Waitrequest and read data as they stand at the rising edge
    do begin
      @(posedge clk_in);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    `TB_CHK(q, {24'h00_0000, e})
  endtask

  // Request level, looked at mid-cycle where it is settled
  task automatic chk_irq(input logic e);
    @(negedge clk_in);
    `TB_CHK(irq, e)
  endtask

  // Write and track the stored value of the sticky bits
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
    if (b[0] && a == `PIRQ_OFS_ANALOG) exp_f.analog = d[7:0] & 8'h43;
    if (b[0] && a == `PIRQ_OFS_SERIAL) exp_f.serial[3:0] = d[3:0];
    if (b[0] && a == `PIRQ_OFS_TIMER) exp_f.timer = d[7:0] & 8'h3f;
  endtask

  task automatic check_all();
    rd_chk(`PIRQ_OFS_ANALOG, exp_f.analog);
    rd_chk(`PIRQ_OFS_SERIAL, ser_exp());
    rd_chk(`PIRQ_OFS_TIMER, exp_f.timer);
    `TB_CHK(flags, {exp_f.analog, ser_exp(), exp_f.timer})
  endtask

  task automatic fire_ev(input pirq_pkg::pirq_events_t e);
    @(posedge clk_in);
    ev <= e;
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
    @(posedge clk_in);
    exp_f = exp_f | ev_flags(e);
  endtask

  task automatic complete_run();
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    pirq_pkg::pirq_events_t e;
    logic [31:0] d;
    void'($urandom(32'h08ee));
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    check_all();
    rd_chk(5'h14, 8'h00);
    $display("test reset done");
    // Random events with random enables, then random stores
    for (int i = 0; i < 24; i++) begin
      ens <= pirq_pkg::pirq_enables_t'(24'($urandom));
      fire_ev(pirq_pkg::pirq_events_t'(22'($urandom)));
      check_all();
      d = $urandom;
      wr_reg(offs[$urandom % 3], d, 4'($urandom));
      check_all();
    end
    wr_reg(5'h14, 32'h0000_00ff, 4'hf);
    rd_chk(5'h14, 8'h00);
    $display("test random done");
    // Set wins over a clearing write in the same cycle
    e = '0;
    e.cmp_a = 1'b1;
    fire_ev(e);
    fork
      wr_reg(`PIRQ_OFS_ANALOG, 32'h0000_0000, 4'h1);
      begin
        @(posedge clk_in);
        ev <= e;
        fire <= 1'b1;
        @(posedge clk_in);
        fire <= 1'b0;
      end
    join
    exp_f.analog[0] = 1'b1;
    check_all();
    $display("test collision done");
    // Buffer level flags and shift-empty status
    ens <= '0;
    @(posedge clk_in);
    rx_push <= 1'b1;
    tx_push <= 1'b1;
    repeat (2) @(posedge clk_in);
    rx_push <= 1'b0;
    tx_push <= 1'b0;
    rx_n = 2;
    tx_n = 2;
    wr_reg(`PIRQ_OFS_SERIAL, 32'h0000_00ff, 4'h1);
    rd_chk(`PIRQ_OFS_SERIAL, ser_exp());
    @(posedge clk_in);
    rx_pop <= 1'b1;
    tx_drain <= 1'b1;
    @(posedge clk_in);
    rx_pop <= 1'b0;
    tx_drain <= 1'b0;
    rx_n = 1;
    tx_n = 1;
    rd_chk(`PIRQ_OFS_SERIAL, ser_exp());
    rd_chk(`PIRQ_OFS_STATUS, 8'h00);
    rx_pop <= 1'b1;
    tx_drain <= 1'b1;
    @(posedge clk_in);
    rx_pop <= 1'b0;
    tx_drain <= 1'b0;
    rx_n = 0;
    tx_n = 0;
    rd_chk(`PIRQ_OFS_SERIAL, ser_exp());
    rd_chk(`PIRQ_OFS_STATUS, 8'h01);
    $display("test buffers done");
    // Request only with the peripheral enable set
    for (int k = 0; k < 3; k++) wr_reg(offs[k], 32'h0, 4'h1);
    ens.analog <= 8'h01;
    fire_ev(e);
    repeat (2) @(posedge clk_in);
    chk_irq(1'b0);
    wr_reg(`PIRQ_OFS_CTRL, 32'h0000_0001, 4'h1);
    rd_chk(`PIRQ_OFS_CTRL, 8'h01);
    chk_irq(1'b1);
    rd_chk(`PIRQ_OFS_STATUS, 8'h03);
    wr_reg(`PIRQ_OFS_ANALOG, 32'h0, 4'h1);
    repeat (2) @(posedge clk_in);
    chk_irq(1'b0);
    $display("test request done");
    // Reset in mid-run clears every stored bit
    fire_ev(pirq_pkg::pirq_events_t'(22'h3f_ffff));
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    exp_f = '0;
    check_all();
    rd_chk(`PIRQ_OFS_CTRL, 8'h00);
    chk_irq(1'b0);
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire

// file: core/pirq_flag_bit.sv
// One sticky flag: set by hardware, written by software.
// Assumes set and write strobes are synchronous to clk_in.
`timescale 1ns/10ps
`default_nettype none

module pirq_flag_bit (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Set and software write
  input wire logic set_in,
  input wire logic wr_in,
  input wire logic wdata_in,
  // Flag value
  output logic flag_out
);

  logic flag_reg;
  logic flag_next;

  // Set wins over a clearing write in the same cycle
  assign flag_next = set_in | (wr_in ? wdata_in : flag_reg);

  // Flag storage, zero after any reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

  // ==========================================================
  // Checks
  set_beats_clear_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) set_in |=> flag_reg)
    else $error("flag lost a set event");

  no_self_clear_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) flag_reg && !wr_in |=> flag_reg)
    else $error("flag cleared without a write");

endmodule

`default_nettype wire

// file: core/pirq_flags.sv
// Peripheral interrupt request flag registers for analog, serial
// and timer events, with an Avalon-MM slave port and a request out.
// Assumes event strobes are one cycle wide and synchronous to clk_in.
//
// Function
// - Zero-cross flag bit 6 sets on enabled rising or falling event.
// - Comparator b sets bit 1, comparator a bit 0; both sticky.
// - Unimplemented bits of the three flag registers read zero.
// - Flags set regardless of individual or global enables.
// - Receive flag bit 5 is high while receive buffer holds data.
// - Writes never clear receive flag; only draining the buffer does.
// - Transmit flag bit 4 is high while transmit buffer has room.
// - Transmit flag shows space only; shift-empty is separate status.
// - Collision flags: bit 3 for sync port b, bit 1 for a.
// - Done flags: bit 2 for sync port b, bit 0 for a.
// - 8-bit timer flags set on postscaler overflow or 1:1 match.
// - 16-bit timer flags bits 4, 2, 0 set on overflow.
// - Hardware-set flags read zero after every reset; bits 5 and 4 follow buffer levels.
// - Hardware-set flags are read/write; hardware never clears them.
// - Interrupt request only while peripheral enable bit is set.
`timescale 1ns/10ps
`default_nettype none
`include "pirq_consts.svh"

module pirq_flags (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Peripheral events and levels
  input wire pirq_pkg::pirq_events_t events_in,
  input wire pirq_pkg::pirq_serial_t serial_in,
  input wire pirq_pkg::pirq_enables_t enables_in,
  // Flag view and interrupt request
  output pirq_pkg::pirq_flags_t flags_out,
  output logic irq_request_out
);

  // ==========================================================
  // Bus handshake
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  wire bus_req = avs_read_in | avs_write_in;
  wire rd_load = avs_read_in & ~ack_reg;
  wire wr_fire = avs_write_in & ack_reg & avs_byteenable_in[0];

  // One wait state on every access
  assign ack_next = bus_req & ~ack_reg;
  assign avs_waitrequest_out = bus_req & ~ack_reg;

  // Address decode
  wire [4:0] word_addr = {avs_address_in[4:2], 2'b00};
  wire sel_analog = (word_addr == `PIRQ_OFS_ANALOG);
  wire sel_serial = (word_addr == `PIRQ_OFS_SERIAL);
  wire sel_timer = (word_addr == `PIRQ_OFS_TIMER);
  wire sel_ctrl = (word_addr == `PIRQ_OFS_CTRL);
  wire sel_status = (word_addr == `PIRQ_OFS_STATUS);
  wire wr_analog = wr_fire & sel_analog;
  wire wr_serial = wr_fire & sel_serial;
  wire wr_timer = wr_fire & sel_timer;
  wire wr_ctrl = wr_fire & sel_ctrl;
  wire [7:0] wbyte = avs_writedata_in[7:0];

  // ==========================================================
  // Event qualification
  wire zc_event = (events_in.zc_rise & events_in.zc_rise_en) |
                  (events_in.zc_fall & events_in.zc_fall_en);
  // Postscaler overflow, or period match when the ratio is 1:1
  wire [2:0] t8_event = events_in.t8_post_ovf |
                        (events_in.t8_match &
                         events_in.t8_ratio_one);

  // Hardware set, write strobe and write data per sticky flag
  wire [`PIRQ_NUM_HW_FLAGS-1:0] set_vec;
  wire [`PIRQ_NUM_HW_FLAGS-1:0] wr_vec;
  wire [`PIRQ_NUM_HW_FLAGS-1:0] wd_vec;
  wire [`PIRQ_NUM_HW_FLAGS-1:0] flag_vec;

  // Sets ignore the individual and peripheral enables; only zero-cross uses its edge enables
  assign set_vec = {t8_event[2], events_in.t16_ovf[2],
                    t8_event[1], events_in.t16_ovf[1],
                    t8_event[0], events_in.t16_ovf[0],
                    events_in.spb_col, events_in.spb_done,
                    events_in.spa_col, events_in.spa_done,
                    zc_event, events_in.cmp_b,
                    events_in.cmp_a};
  assign wr_vec = {{6{wr_timer}}, {4{wr_serial}}, {3{wr_analog}}};
  assign wd_vec = {wbyte[5:0], wbyte[3:0], wbyte[`PIRQ_ZC_BIT],
                   wbyte[`PIRQ_CMPB_BIT], wbyte[`PIRQ_CMPA_BIT]};

  // Sticky flag storage, one cell per flag
  genvar gi;
  generate
    for (gi = 0; gi < `PIRQ_NUM_HW_FLAGS; gi++) begin : g_flag
      pirq_flag_bit u_bit (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .set_in(set_vec[gi]),
        .wr_in(wr_vec[gi]),
        .wdata_in(wd_vec[gi]),
        .flag_out(flag_vec[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Register views
  wire [7:0] analog_view;
  wire [7:0] serial_view;
  wire [7:0] timer_view;

  // Unimplemented positions tie to zero
  assign analog_view = {1'b0, flag_vec[2], 4'h0,
                        flag_vec[1], flag_vec[0]};
  // Buffer levels drive bits 5 and 4 directly, writes cannot touch them
  assign serial_view = {2'b00, serial_in.rx_nonempty,
                        serial_in.tx_space,
                        flag_vec[6:3]};
  assign timer_view = {2'b00, flag_vec[12:7]};
  assign flags_out = {analog_view, serial_view, timer_view};

  // ==========================================================
  // Control and status
  logic peripheral_irq_enable_reg;
  logic peripheral_irq_enable_next;
  logic irq_reg;
  logic irq_next;
  wire any_enabled;
  wire [31:0] ctrl_word;
  wire [31:0] status_word;

  assign peripheral_irq_enable_next = wr_ctrl ? wbyte[`PIRQ_PERIPHERAL_IRQ_ENABLE_BIT] : peripheral_irq_enable_reg;
  // Enabled flags in any of the three registers
  assign any_enabled = |(analog_view & enables_in.analog) |
                       |(serial_view & enables_in.serial) |
                       |(timer_view & enables_in.timer);
  // Request is gated by the peripheral enable
  assign irq_next = any_enabled & peripheral_irq_enable_reg;
  assign ctrl_word = {31'h0000_0000, peripheral_irq_enable_reg};
  // Shift-empty is a separate status bit from the transmit flag
  assign status_word = {30'h0000_0000, any_enabled,
                        serial_in.tx_shift_empty};

  // Read multiplexer, unmapped words read zero
  assign rdata_next = sel_analog ? {24'h00_0000, analog_view} :
                      sel_serial ? {24'h00_0000, serial_view} :
                      sel_timer ? {24'h00_0000, timer_view} :
                      sel_ctrl ? ctrl_word :
                      sel_status ? status_word : `PIRQ_WORD_ZERO;

  // Handshake state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // Read data capture on the first cycle of a read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= `PIRQ_WORD_ZERO;
    end else if (rd_load) begin
      rdata_reg <= rdata_next;
    end
  end

  // Peripheral enable and registered request
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      peripheral_irq_enable_reg <= `PIRQ_CTRL_RESET;
      irq_reg <= 1'b0;
    end else begin
      peripheral_irq_enable_reg <= peripheral_irq_enable_next;
      irq_reg <= irq_next;
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign irq_request_out = irq_reg;

  // ==========================================================
  // Checks
  zero_cross_set_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    events_in.zc_rise && events_in.zc_rise_en
    |=> flags_out.analog[`PIRQ_ZC_BIT])
    else $error("zero-cross event did not set flag");

  zero_cross_quiet_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    !flags_out.analog[`PIRQ_ZC_BIT] && !zc_event && !wr_analog
    |=> !flags_out.analog[`PIRQ_ZC_BIT])
    else $error("zero-cross flag rose without event");

  comparator_set_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    events_in.cmp_b |=> flags_out.analog[`PIRQ_CMPB_BIT] ##0
    (flags_out.analog[`PIRQ_CMPB_BIT] || wr_analog))
    else $error("comparator b flag not set");

  reserved_zero_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    avs_read_in && !avs_waitrequest_out && $past(sel_analog)
    |-> (avs_readdata_out[7:0] & ~`PIRQ_ANALOG_MASK) == 8'h00)
    else $error("reserved analog bits read nonzero");

  timer_reserved_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    avs_read_in && !avs_waitrequest_out && $past(sel_timer || sel_serial)
    |-> avs_readdata_out[7:6] == 2'b00)
    else $error("reserved timer or serial bits set");

  rx_follows_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    avs_read_in && !avs_waitrequest_out && $past(sel_serial)
    |-> avs_readdata_out[`PIRQ_RX_BIT] == $past(serial_in.rx_nonempty))
    else $error("receive flag does not follow buffer");

  tx_follows_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    avs_read_in && !avs_waitrequest_out && $past(sel_serial)
    |-> avs_readdata_out[`PIRQ_TX_BIT] == $past(serial_in.tx_space))
    else $error("transmit flag does not follow buffer");

  sync_col_set_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    events_in.spa_col ##1 !wr_serial [*2]
    |=> flags_out.serial[`PIRQ_SPA_COL_BIT])
    else $error("collision flag not held");

  sync_done_set_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    events_in.spb_done |=> flags_out.serial[`PIRQ_SPB_DONE_BIT])
    else $error("sync port b done flag not set");

  timer8_match_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    events_in.t8_match[1] && events_in.t8_ratio_one[1]
    |=> flags_out.timer[3])
    else $error("timer b8 match at 1:1 did not set flag");

  timer8_nomatch_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    !flags_out.timer[1] && !t8_event[0] && !wr_timer
    |=> !flags_out.timer[1])
    else $error("timer a8 flag rose without event");

  timer16_ovf_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    events_in.t16_ovf[2] |=> flags_out.timer[4])
    else $error("timer c16 overflow did not set flag");

  timer_no_selfclear_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    $fell(flags_out.timer[0]) |-> $past(wr_timer))
    else $error("timer flag cleared by hardware");

  reset_zero_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    $rose(rstn_in) |-> flag_vec == '0 && !irq_request_out)
    else $error("flags not zero after reset");

  irq_gate_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    !peripheral_irq_enable_reg |=> !irq_request_out)
    else $error("request raised with peripheral enable off");

  irq_raise_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    peripheral_irq_enable_reg && any_enabled |=> irq_request_out)
    else $error("request missing for enabled flag");

  one_wait_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    bus_req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("access not answered after one wait state");

endmodule

`default_nettype wire

// file: pkg/pirq_consts.svh
// Offsets, bit positions, masks and reset values of the flag block.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef PIRQ_CONSTS_SVH
`define PIRQ_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define PIRQ_OFS_ANALOG 5'h00
`define PIRQ_OFS_SERIAL 5'h04
`define PIRQ_OFS_TIMER 5'h08
`define PIRQ_OFS_CTRL 5'h0c
`define PIRQ_OFS_STATUS 5'h10

// ==========================================================
// Bit positions, analog_event_flags
`define PIRQ_ZC_BIT 6
`define PIRQ_CMPB_BIT 1
`define PIRQ_CMPA_BIT 0

// Bit positions, serial_event_flags
`define PIRQ_RX_BIT 5
`define PIRQ_TX_BIT 4
`define PIRQ_SPB_COL_BIT 3
`define PIRQ_SPB_DONE_BIT 2
`define PIRQ_SPA_COL_BIT 1
`define PIRQ_SPA_DONE_BIT 0

// Bit positions, control and status words
`define PIRQ_PERIPHERAL_IRQ_ENABLE_BIT 0
`define PIRQ_SHIFT_EMPTY_BIT 0
`define PIRQ_PENDING_BIT 1

// ==========================================================
// Implemented-bit masks and reset values
`define PIRQ_ANALOG_MASK 8'h43
`define PIRQ_SERIAL_MASK 8'h3f
`define PIRQ_TIMER_MASK 8'h3f
`define PIRQ_FLAGS_RESET 8'h00
`define PIRQ_CTRL_RESET 1'b0
`define PIRQ_WORD_ZERO 32'h0000_0000

// Number of hardware-set flag bits
`define PIRQ_NUM_HW_FLAGS 13

`endif

// file: pkg/pirq_pkg.sv
// Types shared by the flag block and its surroundings.
// Assumes the peripherals deliver events as one-cycle strobes.
package pirq_pkg;

  // Event strobes and qualifiers from the peripherals
  typedef struct packed {
    logic zc_rise;
    logic zc_fall;
    logic zc_rise_en;
    logic zc_fall_en;
    logic cmp_a;
    logic cmp_b;
    logic spa_done;
    logic spa_col;
    logic spb_done;
    logic spb_col;
    logic [2:0] t16_ovf;
    logic [2:0] t8_post_ovf;
    logic [2:0] t8_match;
    logic [2:0] t8_ratio_one;
  } pirq_events_t;

  // Buffer levels from the asynchronous serial port
  typedef struct packed {
    logic rx_nonempty;
    logic tx_space;
    logic tx_shift_empty;
  } pirq_serial_t;

  // Individual enables held by the enable registers elsewhere
  typedef struct packed {
    logic [7:0] analog;
    logic [7:0] serial;
    logic [7:0] timer;
  } pirq_enables_t;

  // Flag register contents as seen by the core
  typedef struct packed {
    logic [7:0] analog;
    logic [7:0] serial;
    logic [7:0] timer;
  } pirq_flags_t;

endpackage
